// [pls_pkg.sv]
// Purpose: shared constants for the dual-use indicator/strap pin block
// Assumes: 10 MHz sys_clk, 32-bit register bus with byte addresses
// Notes:   register indices map to byte address = index * 4
package pls_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned ACT_BLINK_MS    = 50;
    localparam int unsigned ACT_TICK_CYCLES = (ACT_BLINK_MS * (CLK_HZ / 1000) > 0) ?
                                              ACT_BLINK_MS * (CLK_HZ / 1000) : 1;
    localparam int unsigned BLINK_CNT_W     = 24;

    // register indices
    localparam logic [5:0] IDX_CTRL0      = 6'h00;
    localparam logic [5:0] IDX_VENDOR_1F  = 6'h1f;
    localparam logic [5:0] IDX_INT_STATUS = 6'h20;
    localparam logic [5:0] IDX_INT_MASK   = 6'h21;
    localparam logic [5:0] IDX_LINE_STATE = 6'h22;

    // control register 0 fields
    localparam int unsigned CTRL0_SPEED_BIT   = 13;
    localparam int unsigned CTRL0_ANEG_BIT    = 12;
    localparam int unsigned CTRL0_DUPLEX_BIT  = 8;
    // vendor register 0x1f field
    localparam int unsigned VEND_INT_POL_BIT  = 9;
    localparam logic        VEND_INT_POL_RST  = 1'b0;

    // interrupt events
    localparam int unsigned EV_COUNT  = 3;
    localparam int unsigned EV_LINK   = 0;
    localparam int unsigned EV_MODE   = 1;
    localparam int unsigned EV_COL    = 2;
    localparam logic [EV_COUNT-1:0] INT_MASK_RST = 3'h0;

    // line state fields
    localparam int unsigned LS_LINK     = 0;
    localparam int unsigned LS_SPEED    = 1;
    localparam int unsigned LS_DUPLEX   = 2;
    localparam int unsigned LS_COL      = 3;
    localparam int unsigned LS_TEST     = 4;
    localparam int unsigned LS_ADDR0    = 5;

    // pin order on the synchroniser
    localparam int unsigned PIN_COUNT   = 5;
    localparam int unsigned PIN_IRQ     = 0;
    localparam int unsigned PIN_LINKACT = 1;
    localparam int unsigned PIN_SPEED   = 2;
    localparam int unsigned PIN_DUPLEX  = 3;
    localparam int unsigned PIN_COL     = 4;

    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : pls_pkg

// [pls_pin_sync.sv]
// Purpose: two-flop synchroniser for the pad inputs
// Assumes: inputs are asynchronous to sys_clk
// Notes:   no reset, so strap levels flow through while reset is held
module pls_pin_sync
    import pls_pkg::*;
#(
    parameter int unsigned W = PIN_COUNT
) (
    input  wire logic         sys_clk,
    input  wire logic [W-1:0] pinRaw,
    output logic      [W-1:0] pinSync
);
    logic [W-1:0] stage1;

    always_ff @(posedge sys_clk) begin
        stage1  <= pinRaw;
        pinSync <= stage1;
    end
endmodule : pls_pin_sync

// [pls_blink.sv]
// Purpose: activity blink generator for the link/activity indicator
// Assumes: activity is a same-clock pulse or level from the receive logic
// Notes:   one blink phase per tick; a short burst still shows one blink
module pls_blink
    import pls_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = ACT_TICK_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic activity,
    input  wire logic linkUp,
    output logic      ledOn
);
    logic [BLINK_CNT_W-1:0] cnt;
    logic [BLINK_CNT_W-1:0] next_cnt;
    logic                   pending;
    logic                   next_pending;
    logic                   phase;
    logic                   next_phase;
    logic                   tick;

    always_comb begin
        tick         = (cnt == BLINK_CNT_W'(TICK_CYCLES - 1));
        next_cnt     = tick ? '0 : cnt + 1'b1;
        next_pending = pending | activity;
        next_phase   = phase;
        if (tick) begin
            next_pending = activity;
            next_phase   = pending ? ~phase : 1'b0;
        end
        if (!rst_n) begin
            next_cnt     = '0;
            next_pending = 1'b0;
            next_phase   = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        cnt     <= next_cnt;
        pending <= next_pending;
        phase   <= next_phase;
    end

    // off phase of a blink blanks the lamp
    assign ledOn = linkUp & ~phase;
endmodule : pls_blink

// [pls_led_strap.sv]
// Purpose: dual-use strap / indicator pins with register access
// Assumes: line status inputs come from logic on sys_clk
// Notes:   pins stay inputs through reset; straps seed control register 0
// Function
// (R1) interrupt pin strap sets management address bit0
// (R2) interrupt pin output, polarity from vendor bit9
// (R3) link/activity lamp active low, toggles on activity
// (R4) link/activity pulled low at reset: test mode
// (R5) speed pin strap into control bit13
// (R6) speed lamp low for 100M, high 10M
// (R7) duplex pin strap into control bit8
// (R8) duplex lamp low full, high half
// (R9) collision pin strap into autoneg bit12
// (R10) collision lamp high when no collision
// (R11) collision lamp low; pins output after release
//
// Design decisions made here: the address map and register access over Avalon-MM.
module pls_led_strap
    import pls_pkg::*;
#(
    parameter int unsigned ACT_TICK = ACT_TICK_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // line status from the transceiver core
    input  wire logic        linkUp,
    input  wire logic        activity,
    input  wire logic        speed100,
    input  wire logic        fullDuplex,
    input  wire logic        collision,
    // dual-use pins
    input  wire logic        irqPinIn,
    output logic             irqPinOut,
    output logic             irqPinOe,
    input  wire logic        linkActPinIn,
    output logic             linkActPinOut,
    output logic             linkActPinOe,
    input  wire logic        speedPinIn,
    output logic             speedPinOut,
    output logic             speedPinOe,
    input  wire logic        duplexPinIn,
    output logic             duplexPinOut,
    output logic             duplexPinOe,
    input  wire logic        colPinIn,
    output logic             colPinOut,
    output logic             colPinOe,
    // configuration to the rest of the device
    output logic             mgmtAddrBit0,
    output logic             testMode,
    output logic             speedSel,
    output logic             autonegEnable,
    output logic             duplexSel,
    output logic             irq
);
    logic [PIN_COUNT-1:0] pinSync;
    logic                 blinkOn;

    pls_pin_sync #(.W(PIN_COUNT)) u_sync (
        .sys_clk (sys_clk),
        .pinRaw  ({colPinIn, duplexPinIn, speedPinIn, linkActPinIn, irqPinIn}),
        .pinSync (pinSync)
    );

    pls_blink #(.TICK_CYCLES(ACT_TICK)) u_blink (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .activity (activity),
        .linkUp   (linkUp),
        .ledOn    (blinkOn)
    );

    function automatic logic regHit(input logic [7:0] addr, input logic [5:0] idx);
        regHit = (addr == {idx, 2'b00});
    endfunction : regHit

    // ---------------- configuration, straps, interrupts, bus
    logic                next_mgmtAddrBit0;
    logic                next_testMode;
    logic                next_speedSel;
    logic                next_autonegEnable;
    logic                next_duplexSel;
    logic                intActiveHigh;
    logic                next_intActiveHigh;
    logic [EV_COUNT-1:0] intStatus;
    logic [EV_COUNT-1:0] next_intStatus;
    logic [EV_COUNT-1:0] intMask;
    logic [EV_COUNT-1:0] next_intMask;
    logic                prevLink;
    logic                prevMode;
    logic                prevCol;
    logic                next_prevLink;
    logic                next_prevMode;
    logic                next_prevCol;
    logic                next_irq;
    logic                next_waitrequest;
    logic [31:0]         next_readdata;
    logic [EV_COUNT-1:0] events;
    logic [EV_COUNT-1:0] clearBits;
    logic                wrTaken;
    logic                modeNow;
    logic [31:0]         rdValue;

    always_comb begin
        next_mgmtAddrBit0  = mgmtAddrBit0;
        next_testMode      = testMode;
        next_speedSel      = speedSel;
        next_autonegEnable = autonegEnable;
        next_duplexSel     = duplexSel;
        next_intActiveHigh = intActiveHigh;
        next_intMask       = intMask;
        modeNow            = speed100 ^ fullDuplex;
        next_prevLink      = linkUp;
        next_prevMode      = modeNow;
        next_prevCol       = collision;
        events             = '0;
        events[EV_LINK]    = linkUp ^ prevLink;
        events[EV_MODE]    = (speed100 ^ fullDuplex) ^ prevMode;
        events[EV_COL]     = collision & ~prevCol;
        wrTaken            = write & ~waitrequest;
        clearBits          = '0;

        rdValue = READ_ZERO;
        if (regHit(address, IDX_CTRL0)) begin
            rdValue[CTRL0_SPEED_BIT]  = speedSel;
            rdValue[CTRL0_ANEG_BIT]   = autonegEnable;
            rdValue[CTRL0_DUPLEX_BIT] = duplexSel;
        end else if (regHit(address, IDX_VENDOR_1F)) begin
            rdValue[VEND_INT_POL_BIT] = intActiveHigh;
        end else if (regHit(address, IDX_INT_STATUS)) begin
            rdValue[EV_COUNT-1:0] = intStatus;
        end else if (regHit(address, IDX_INT_MASK)) begin
            rdValue[EV_COUNT-1:0] = intMask;
        end else if (regHit(address, IDX_LINE_STATE)) begin
            rdValue[LS_LINK]   = linkUp;
            rdValue[LS_SPEED]  = speed100;
            rdValue[LS_DUPLEX] = fullDuplex;
            rdValue[LS_COL]    = collision;
            rdValue[LS_TEST]   = testMode;
            rdValue[LS_ADDR0]  = mgmtAddrBit0;
        end

        if (wrTaken) begin
            if (regHit(address, IDX_CTRL0)) begin
                if (byteenable[1]) begin
                    next_speedSel      = writedata[CTRL0_SPEED_BIT];
                    next_autonegEnable = writedata[CTRL0_ANEG_BIT];
                    next_duplexSel     = writedata[CTRL0_DUPLEX_BIT];
                end
            end else if (regHit(address, IDX_VENDOR_1F)) begin
                if (byteenable[1]) begin
                    next_intActiveHigh = writedata[VEND_INT_POL_BIT];
                end
            end else if (regHit(address, IDX_INT_STATUS)) begin
                if (byteenable[0]) begin
                    clearBits = writedata[EV_COUNT-1:0];
                end
            end else if (regHit(address, IDX_INT_MASK)) begin
                if (byteenable[0]) begin
                    next_intMask = writedata[EV_COUNT-1:0];
                end
            end
        end
        // a new event beats a same-cycle clear
        next_intStatus   = (intStatus & ~clearBits) | events;
        next_irq         = |(intStatus & intMask);
        // one wait cycle, then a single ready cycle
        next_waitrequest = ~((read | write) & waitrequest);
        next_readdata    = ((read | write) & waitrequest) ? rdValue : readdata;

        if (!rst_n) begin
            // pads are still inputs here, so their pulls are visible
            next_mgmtAddrBit0  = pinSync[PIN_IRQ];          // R1
            next_testMode      = ~pinSync[PIN_LINKACT];     // R4
            next_speedSel      = pinSync[PIN_SPEED];        // R5
            next_duplexSel     = pinSync[PIN_DUPLEX];       // R7
            next_autonegEnable = pinSync[PIN_COL];          // R9
            next_intActiveHigh = VEND_INT_POL_RST;
            next_intMask       = INT_MASK_RST;
            next_intStatus     = '0;
            next_prevLink      = 1'b0;
            next_prevMode      = 1'b0;
            next_prevCol       = 1'b0;
            next_irq           = 1'b0;
            next_waitrequest   = 1'b1;
            next_readdata      = READ_ZERO;
        end
    end

    always_ff @(posedge sys_clk) begin
        mgmtAddrBit0  <= next_mgmtAddrBit0;
        testMode      <= next_testMode;
        speedSel      <= next_speedSel;
        autonegEnable <= next_autonegEnable;
        duplexSel     <= next_duplexSel;
        intActiveHigh <= next_intActiveHigh;
        intStatus     <= next_intStatus;
        intMask       <= next_intMask;
        prevLink      <= next_prevLink;
        prevMode      <= next_prevMode;
        prevCol       <= next_prevCol;
        irq           <= next_irq;
        waitrequest   <= next_waitrequest;
        readdata      <= next_readdata;
    end

    // ---------------- pin drivers
    logic next_pinOe;
    logic next_irqPinOut;
    logic next_linkActPinOut;
    logic next_speedPinOut;
    logic next_duplexPinOut;
    logic next_colPinOut;

    always_comb begin
        next_pinOe         = rst_n;                              // R11
        next_irqPinOut     = intActiveHigh ? (|(intStatus & intMask))
                                           : ~(|(intStatus & intMask)); // R2
        next_linkActPinOut = ~blinkOn;                           // R3
        next_speedPinOut   = ~speed100;                          // R6
        next_duplexPinOut  = ~fullDuplex;                        // R8
        next_colPinOut     = ~collision;                         // R10 R11
        if (!rst_n) begin
            next_irqPinOut     = 1'b1;
            next_linkActPinOut = 1'b1;
            next_speedPinOut   = 1'b1;
            next_duplexPinOut  = 1'b1;
            next_colPinOut     = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        irqPinOe      <= next_pinOe;
        linkActPinOe  <= next_pinOe;
        speedPinOe    <= next_pinOe;
        duplexPinOe   <= next_pinOe;
        colPinOe      <= next_pinOe;
        irqPinOut     <= next_irqPinOut;
        linkActPinOut <= next_linkActPinOut;
        speedPinOut   <= next_speedPinOut;
        duplexPinOut  <= next_duplexPinOut;
        colPinOut     <= next_colPinOut;
    end

    // ---------------- checks
    sequence busReq;
        (read | write) & waitrequest;
    endsequence

    sequence busAnswer;
        !waitrequest ##1 waitrequest;
    endsequence

    a_strap_addr: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
        $rose(rst_n) |-> mgmtAddrBit0 == $past(pinSync[PIN_IRQ]))
        else $error("address strap not captured");

    a_strap_test: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
        $rose(rst_n) |-> testMode == !$past(pinSync[PIN_LINKACT]))
        else $error("test mode strap not captured");

    a_strap_speed: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
        $rose(rst_n) |-> speedSel == $past(pinSync[PIN_SPEED]))
        else $error("speed strap not captured");

    a_strap_duplex: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
        $rose(rst_n) |-> duplexSel == $past(pinSync[PIN_DUPLEX]))
        else $error("duplex strap not captured");

    a_strap_aneg: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
        $rose(rst_n) |-> autonegEnable == $past(pinSync[PIN_COL]))
        else $error("autoneg strap not captured");

    a_pin_turnon: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        $rose(rst_n) |-> !colPinOe && !speedPinOe ##1 colPinOe && speedPinOe)
        else $error("pin enable timing wrong");

    a_link_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
        linkActPinOe && !linkUp |=> linkActPinOut)
        else $error("link lamp lit without link");

    a_speed_lamp: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
        speedPinOe |=> speedPinOut == !$past(speed100))
        else $error("speed lamp wrong");

    a_duplex_lamp: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        duplexPinOe |=> duplexPinOut == !$past(fullDuplex))
        else $error("duplex lamp wrong");

    a_col_lamp: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
        colPinOe |=> colPinOut == !$past(collision))
        else $error("collision lamp wrong");

    a_irq_polarity: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
        irqPinOe |=> irqPinOut == ($past(intActiveHigh) ~^ $past(|(intStatus & intMask))))
        else $error("interrupt pin level wrong");

    a_col_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        collision && !prevCol |=> intStatus[EV_COL])
        else $error("collision event lost");

    // set must survive a same-cycle write-one clear
    a_event_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        |events |=> (intStatus & $past(events)) == $past(events))
        else $error("status event lost");

    a_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busReq |=> busAnswer)
        else $error("bus answer timing wrong");
endmodule : pls_led_strap

// [pls_board.sv]
// Purpose: board side of the dual-use pins: strap pulls and lamp loads
// Assumes: one pull resistor per pad, lamps load the pad only
// Notes:   a pad the block does not drive, or whose enable is unknown, sits at its pull
module pls_board
    import pls_pkg::*;
(
    input  wire logic [PIN_COUNT-1:0] strap,
    input  wire logic [PIN_COUNT-1:0] pinOut,
    input  wire logic [PIN_COUNT-1:0] pinOe,
    output logic      [PIN_COUNT-1:0] pinIn
);
    // released pad returns to the pull level, never the last driven value
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            pinIn[i] = (pinOe[i] === 1'b1) ? pinOut[i] : strap[i];
        end
    end
endmodule : pls_board

// [tb_top.sv]
// Purpose: self-checking bench for the strap and indicator pin block
// Assumes: short blink tick so the activity toggle shows within a few cycles
// Notes:   all stimulus changes by non-blocking assignment on the rising edge
module tb_top
    import pls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned TICK = 8;

    logic                 sys_clk;
    logic                 rst_n;
    logic [7:0]           address;
    logic                 read;
    logic                 write;
    logic [31:0]          writedata;
    logic [3:0]           byteenable;
    logic [31:0]          readdata;
    logic                 waitrequest;
    logic                 linkUp;
    logic                 activity;
    logic                 speed100;
    logic                 fullDuplex;
    logic                 collision;
    logic [PIN_COUNT-1:0] strap;
    logic [PIN_COUNT-1:0] pOut;
    logic [PIN_COUNT-1:0] pOe;
    logic [PIN_COUNT-1:0] pIn;
    logic                 mgmtAddrBit0;
    logic                 testMode;
    logic                 speedSel;
    logic                 autonegEnable;
    logic                 duplexSel;
    logic                 irq;
    logic [31:0]          q;
    int                   miscompares;
    int                   total_checks;
    int                   hi;
    int                   lo;

    pls_led_strap #(.ACT_TICK(TICK)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .linkUp(linkUp), .activity(activity), .speed100(speed100), .fullDuplex(fullDuplex),
        .collision(collision),
        .irqPinIn(pIn[PIN_IRQ]), .irqPinOut(pOut[PIN_IRQ]), .irqPinOe(pOe[PIN_IRQ]),
        .linkActPinIn(pIn[PIN_LINKACT]), .linkActPinOut(pOut[PIN_LINKACT]), .linkActPinOe(pOe[PIN_LINKACT]),
        .speedPinIn(pIn[PIN_SPEED]), .speedPinOut(pOut[PIN_SPEED]), .speedPinOe(pOe[PIN_SPEED]),
        .duplexPinIn(pIn[PIN_DUPLEX]), .duplexPinOut(pOut[PIN_DUPLEX]), .duplexPinOe(pOe[PIN_DUPLEX]),
        .colPinIn(pIn[PIN_COL]), .colPinOut(pOut[PIN_COL]), .colPinOe(pOe[PIN_COL]),
        .mgmtAddrBit0(mgmtAddrBit0), .testMode(testMode), .speedSel(speedSel),
        .autonegEnable(autonegEnable), .duplexSel(duplexSel), .irq(irq)
    );

    pls_board board_u (
        .strap(strap), .pinOut(pOut), .pinOe(pOe), .pinIn(pIn)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
            miscompares++;
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    // request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        address   <= a;
        writedata <= d;
        read      <= !wr;
        write     <= wr;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            miscompares++;
            end_sim();
        end
    endtask : bus

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, q & m, e);
    endtask : rchk

    // low edges: n, all after the setting edge; pads are released from the first of them on
    task automatic do_reset(input logic [4:0] s, input int n);
        @(posedge sys_clk);
        strap <= s;
        rst_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        chk("pinOeInReset", pOe, 32'h0000_0000);
        rst_n <= 1'b1;
        cyc(2);
        chk("mgmtAddrBit0", mgmtAddrBit0, s[0]);
        chk("testMode", testMode, !s[1]);
        chk("speedSel", speedSel, s[2]);
        chk("duplexSel", duplexSel, s[3]);
        chk("autonegEnable", autonegEnable, s[4]);
        chk("pinOeAfter", pOe, 32'h0000_001f);
        rchk(8'h00, 32'h0000_3100, {18'h0, s[2], s[4], 3'h0, s[3], 8'h00}, "ctrl0");
        rchk(8'h88, 32'h0000_0030, {26'h0, s[0], !s[1], 4'h0}, "lineState");
    endtask : do_reset

    initial begin
        rst_n = 1'b0;
        strap = 5'b01000;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'hf;
        linkUp = 1'b0;
        activity = 1'b0;
        speed100 = 1'b0;
        fullDuplex = 1'b0;
        collision = 1'b0;
        miscompares = 0;
        total_checks = 0;
        do_reset(5'b01000, 2);
        // second reset mid-run: pads must be released before straps resample
        do_reset(5'b10111, 4);
        cyc(3);
        chk("linkOff", pIn[PIN_LINKACT], 1'b1);
        chk("speed10", pIn[PIN_SPEED], 1'b1);
        chk("half", pIn[PIN_DUPLEX], 1'b1);
        chk("noCol", pIn[PIN_COL], 1'b1);
        linkUp <= 1'b1;
        speed100 <= 1'b1;
        fullDuplex <= 1'b1;
        cyc(3);
        chk("linkOn", pIn[PIN_LINKACT], 1'b0);
        chk("speed100", pIn[PIN_SPEED], 1'b0);
        chk("full", pIn[PIN_DUPLEX], 1'b0);
        rchk(8'h88, 32'h0000_000f, 32'h0000_0007, "lineLive");
        // speed and duplex rose together, so only the link event is seen
        rchk(8'h80, 32'h0000_0007, 32'h0000_0001, "statusLink");
        activity <= 1'b1;
        hi = 0;
        lo = 0;
        repeat (6 * TICK) begin
            @(posedge sys_clk);
            if (pIn[PIN_LINKACT] === 1'b1) hi++;
            if (pIn[PIN_LINKACT] === 1'b0) lo++;
        end
        chk("blink", {31'h0, hi > 0 && lo > 0}, 32'h0000_0001);
        activity <= 1'b0;
        bus(1'b1, 8'h84, 32'h0000_0004);
        bus(1'b1, 8'h80, 32'h0000_0007);
        cyc(3);
        chk("irqIdle", irq, 1'b0);
        chk("irqPinIdle", pIn[PIN_IRQ], 1'b1);
        collision <= 1'b1;
        cyc(4);
        chk("colOn", pIn[PIN_COL], 1'b0);
        chk("irqSet", irq, 1'b1);
        chk("irqPinLow", pIn[PIN_IRQ], 1'b0);
        rchk(8'h80, 32'h0000_0007, 32'h0000_0004, "status");
        collision <= 1'b0;
        bus(1'b1, 8'h7c, 32'h0000_0200);
        cyc(3);
        chk("colOff", pIn[PIN_COL], 1'b1);
        chk("irqPinHigh", pIn[PIN_IRQ], 1'b1);
        rchk(8'h7c, 32'h0000_0200, 32'h0000_0200, "vendor");
        // lane 1 disabled: polarity bit must not move
        byteenable <= 4'h1;
        bus(1'b1, 8'h7c, 32'h0000_0000);
        byteenable <= 4'hf;
        rchk(8'h7c, 32'h0000_0200, 32'h0000_0200, "vendorLaneOff");
        bus(1'b1, 8'h80, 32'h0000_0004);
        cyc(3);
        chk("irqClear", irq, 1'b0);
        chk("irqPinRel", pIn[PIN_IRQ], 1'b0);
        // masked event: sticky bit set but the line stays quiet
        bus(1'b1, 8'h84, 32'h0000_0000);
        collision <= 1'b1;
        cyc(4);
        chk("irqMasked", irq, 1'b0);
        rchk(8'h80, 32'h0000_0004, 32'h0000_0004, "statusMasked");
        collision <= 1'b0;
        rchk(8'hf0, 32'hffff_ffff, 32'h0000_0000, "unmapped");
        // duplex alone changes: mode event and lamp off
        fullDuplex <= 1'b0;
        cyc(3);
        chk("halfAgain", pIn[PIN_DUPLEX], 1'b1);
        rchk(8'h80, 32'h0000_0002, 32'h0000_0002, "statusMode");
        end_sim();
    end
endmodule : tb_top
